// *** hdl/olied_pkg.sv ***
package olied_pkg;

  // ----------------------------------------------------------------
  // Operating states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT     = 3'h0,
    ST_STOP     = 3'h1,
    ST_GO       = 3'h2,
    ST_SHORT    = 3'h3,
    ST_UPD_SELF = 3'h4,
    ST_UPD_EXT  = 3'h5
  } olied_state_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_MS = 125;
  localparam int unsigned DIV_W = 9;

  // ----------------------------------------------------------------
  // Short-circuit delay: code 0 disables, code n means n steps, codes above SC_MAX_CODE mean SC_MAX_CODE steps
  // ----------------------------------------------------------------
  localparam int unsigned SC_W = 11;
  localparam logic [7:0] SC_OFF_CODE = 8'h00;
  localparam logic [7:0] SC_MAX_CODE = 8'hc8;
  localparam logic [7:0] SC_DEF_CODE = 8'h14;
  localparam logic [SC_W-1:0] SC_STEP_MS = 11'h005;
  localparam logic [SC_W-1:0] SC_CNT_MAX = 11'h7ff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic is_speed;
    logic [13:0] addr;
    logic [7:0] data;
  } olied_cmd_s;

  typedef struct packed {
    logic red;
    logic grn;
    logic rear;
  } olied_led_s;

  localparam logic [7:0] SPEED_ZERO = 8'h00;
  localparam olied_led_s LED_RST = 3'h0;
  localparam olied_cmd_s CMD_RST = 24'h000000;

endpackage : olied_pkg

// *** hdl/olied_flash.sv ***
`timescale 1ns/100ps

module olied_flash #(
  parameter int unsigned MS_CYCLES = olied_pkg::MS_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic ms_tick,
  output logic slow_ph,
  output logic fast_ph
);

  localparam int unsigned MS_W = $clog2(MS_CYCLES + 1);

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [MS_W-1:0] ms_cnt_q, ms_cnt_d;
  logic [1:0] ph;

  always_comb begin
    ms_tick = (ms_cnt_q == MS_W'(MS_CYCLES - 1));
    ms_cnt_d = ms_tick ? '0 : ms_cnt_q + MS_W'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Half-period dividers, slow then fast
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_div
    localparam logic [olied_pkg::DIV_W-1:0] HALF = (g == 0) ?
      olied_pkg::DIV_W'(olied_pkg::SLOW_HALF_MS - 1) :
      olied_pkg::DIV_W'(olied_pkg::FAST_HALF_MS - 1);
    logic [olied_pkg::DIV_W-1:0] cnt_q, cnt_d;
    logic ph_q, ph_d;

    always_comb begin
      cnt_d = cnt_q;
      ph_d = ph_q;
      if (ms_tick) begin
        if (cnt_q == HALF) begin
          cnt_d = '0;
          ph_d = ~ph_q;
        end else begin
          cnt_d = cnt_q + olied_pkg::DIV_W'(1);
        end
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= '0;
        ph_q <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        ph_q <= ph_d;
      end
    end

    assign ph[g] = ph_q;

    div_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cnt_q <= HALF) else $error("flash divider over half period");
  end

  assign slow_ph = ph[0];
  assign fast_ph = ph[1];

endmodule : olied_flash

// *** hdl/olied_top.sv ***
`timescale 1ns/100ps

module olied_top #(
  parameter int unsigned MS_CYCLES = olied_pkg::MS_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic btn_stop,
  input wire logic btn_go,
  input wire logic short_ext,
  input wire logic short_int,
  input wire logic ext_upd_req,
  input wire logic trk_sig_ok,
  input wire logic brake_cfg,
  input wire logic [7:0] sc_delay_code,
  input wire olied_pkg::olied_cmd_s cmd_in,
  output olied_pkg::olied_cmd_s cmd_out,
  output olied_pkg::olied_led_s led,
  output logic trk_pwr
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q, rst_n_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Flash timing
  // ----------------------------------------------------------------
  logic ms_tick, slow_ph, fast_ph;

  olied_flash #(
    .MS_CYCLES(MS_CYCLES)
  ) u_flash (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .ms_tick(ms_tick),
    .slow_ph(slow_ph),
    .fast_ph(fast_ph)
  );

  function automatic logic [olied_pkg::SC_W-1:0] sc_limit(input logic [7:0] code);
    logic [7:0] c;
    c = (code > olied_pkg::SC_MAX_CODE) ? olied_pkg::SC_MAX_CODE : code;
    return olied_pkg::SC_W'(c) * olied_pkg::SC_STEP_MS;
  endfunction : sc_limit

  // ----------------------------------------------------------------
  // Operating state and short detection
  // ----------------------------------------------------------------
  olied_pkg::olied_state_e state_q, state_d;
  logic [olied_pkg::SC_W-1:0] sc_ms_q, sc_ms_d;
  logic int_sc_q, int_sc_d;
  logic trk_pwr_q, trk_pwr_d;
  logic short_any, trip;

  always_comb begin
    short_any = short_ext | short_int;
    trip = (state_q == olied_pkg::ST_GO) && short_any &&
           (sc_delay_code != olied_pkg::SC_OFF_CODE) &&
           (sc_ms_q >= sc_limit(sc_delay_code));
    sc_ms_d = '0;
    if ((state_q == olied_pkg::ST_GO) && short_any) begin
      sc_ms_d = sc_ms_q;
      if (ms_tick && (sc_ms_q != olied_pkg::SC_CNT_MAX)) begin
        sc_ms_d = sc_ms_q + olied_pkg::SC_W'(1);
      end
    end
    state_d = state_q;
    int_sc_d = int_sc_q;
    case (state_q)
      olied_pkg::ST_INIT: begin
        if (btn_stop && btn_go) begin
          state_d = olied_pkg::ST_UPD_SELF;
        end else begin
          state_d = olied_pkg::ST_STOP;
        end
      end
      olied_pkg::ST_STOP: begin
        if (ext_upd_req) begin
          state_d = olied_pkg::ST_UPD_EXT;
        end else if (btn_go && !btn_stop) begin
          state_d = olied_pkg::ST_GO;
        end
      end
      olied_pkg::ST_GO: begin
        if (ext_upd_req) begin
          state_d = olied_pkg::ST_UPD_EXT;
        end else if (trip) begin
          state_d = olied_pkg::ST_SHORT;
          int_sc_d = short_int;
        end else if (btn_stop) begin
          state_d = olied_pkg::ST_STOP;
        end
      end
      olied_pkg::ST_SHORT: begin
        if (ext_upd_req) begin
          state_d = olied_pkg::ST_UPD_EXT;
          int_sc_d = 1'b0;
        end else if (btn_go && !btn_stop) begin
          state_d = olied_pkg::ST_GO;
          int_sc_d = 1'b0;
        end
      end
      olied_pkg::ST_UPD_SELF: state_d = olied_pkg::ST_UPD_SELF;
      olied_pkg::ST_UPD_EXT: state_d = olied_pkg::ST_UPD_EXT;
      default: state_d = olied_pkg::ST_STOP;
    endcase
    trk_pwr_d = (state_d == olied_pkg::ST_GO);
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= olied_pkg::ST_INIT;
      sc_ms_q <= '0;
      int_sc_q <= 1'b0;
      trk_pwr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sc_ms_q <= sc_ms_d;
      int_sc_q <= int_sc_d;
      trk_pwr_q <= trk_pwr_d;
    end
  end

  assign trk_pwr = trk_pwr_q;

  // ----------------------------------------------------------------
  // LED patterns
  // ----------------------------------------------------------------
  olied_pkg::olied_led_s led_q, led_d;

  always_comb begin
    led_d = olied_pkg::LED_RST;
    case (state_q)
      olied_pkg::ST_STOP: led_d.red = 1'b1;
      olied_pkg::ST_GO: led_d.grn = 1'b1;
      olied_pkg::ST_SHORT: led_d.red = fast_ph;
      olied_pkg::ST_UPD_SELF: led_d.red = slow_ph;
      olied_pkg::ST_UPD_EXT: begin
        led_d.red = slow_ph;
        led_d.grn = ~slow_ph;
      end
      default: led_d.red = 1'b0;
    endcase
    if ((state_q == olied_pkg::ST_SHORT) && int_sc_q) begin
      led_d.rear = fast_ph;
    end else if (trk_pwr_q && trk_sig_ok) begin
      led_d.rear = 1'b1;
    end else begin
      led_d.rear = slow_ph;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      led_q <= olied_pkg::LED_RST;
    end else begin
      led_q <= led_d;
    end
  end

  assign led = led_q;

  // ----------------------------------------------------------------
  // Vehicle command path
  // ----------------------------------------------------------------
  olied_pkg::olied_cmd_s cmd_q, cmd_d;

  always_comb begin
    cmd_d = cmd_in;
    if (brake_cfg && cmd_in.valid && cmd_in.is_speed) begin
      cmd_d.data = olied_pkg::SPEED_ZERO;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_q <= olied_pkg::CMD_RST;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  assign cmd_out = cmd_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_q);

  sequence short_seen_s;
    state_q == olied_pkg::ST_SHORT;
  endsequence

  sequence go_pressed_s;
    btn_go && !btn_stop && !ext_upd_req;
  endsequence

  stop_leds_a: assert property ((state_q == olied_pkg::ST_STOP) |=>
    (led_q.red && !led_q.grn)) else $error("stop LEDs wrong");

  go_leds_a: assert property ((state_q == olied_pkg::ST_GO) |=>
    (led_q.grn && !led_q.red)) else $error("go LEDs wrong");

  short_flash_a: assert property (short_seen_s |-> !trk_pwr_q ##1
    (led_q.red == $past(fast_ph)) && !led_q.grn) else $error("short display wrong");

  short_hold_a: assert property ((short_seen_s ##0 (!(btn_go && !btn_stop) && !ext_upd_req))
    |=> short_seen_s) else $error("short left without go");

  go_resume_a: assert property (short_seen_s ##0 go_pressed_s |=>
    (state_q == olied_pkg::ST_GO) && trk_pwr_q) else $error("go did not resume");

  upd_entry_a: assert property ((state_q == olied_pkg::ST_INIT) && btn_stop && btn_go
    |=> (state_q == olied_pkg::ST_UPD_SELF) ##1 !led_q.grn) else $error("no update entry");

  upd_self_a: assert property ((state_q == olied_pkg::ST_UPD_SELF) |=>
    (state_q == olied_pkg::ST_UPD_SELF) && !led_q.grn && (led_q.red == $past(slow_ph)))
    else $error("self update wrong");

  upd_ext_a: assert property ((state_q == olied_pkg::ST_UPD_EXT) |=>
    (state_q == olied_pkg::ST_UPD_EXT) && (led_q.red != led_q.grn))
    else $error("external update wrong");

  rear_on_a: assert property (trk_pwr_q && trk_sig_ok |=> led_q.rear)
    else $error("rear LED not steady");

  rear_slow_a: assert property (!trk_pwr_q && (state_q != olied_pkg::ST_SHORT)
    |=> led_q.rear == $past(slow_ph)) else $error("rear LED not slow");

  rear_fast_a: assert property (short_seen_s ##0 int_sc_q |-> !trk_pwr_q ##1
    led_q.rear == $past(fast_ph)) else $error("rear LED not fast");

  brake_zero_a: assert property (brake_cfg && cmd_in.valid && cmd_in.is_speed |=>
    cmd_out.valid && (cmd_out.data == olied_pkg::SPEED_ZERO)) else $error("speed not zero");

  func_pass_a: assert property (cmd_in.valid && !cmd_in.is_speed |=>
    cmd_out == $past(cmd_in)) else $error("function command altered");

  stop_keep_a: assert property ((state_q == olied_pkg::ST_STOP) && !brake_cfg
    |=> cmd_out == $past(cmd_in)) else $error("commands lost in stop");

  trip_delay_a: assert property ((state_q == olied_pkg::ST_GO) &&
    (state_d == olied_pkg::ST_SHORT) |-> (sc_delay_code != olied_pkg::SC_OFF_CODE) &&
    (sc_ms_q >= sc_limit(sc_delay_code))) else $error("short tripped early");

endmodule : olied_top

// *** sim/olied_oper.sv ***
`timescale 1ns/100ps

module olied_oper (
  input wire logic clk_sys,
  output logic btn_stop,
  output logic btn_go,
  output logic short_ext,
  output logic short_int
);
  initial begin
    btn_stop = 1'b0;
    btn_go = 1'b0;
    short_ext = 1'b0;
    short_int = 1'b0;
  end

  // ----------------------------------------------------------------
  // Button presses, one cycle long
  // ----------------------------------------------------------------
  task automatic press(input logic s, input logic g);
    @(negedge clk_sys);
    btn_stop = s;
    btn_go = g;
    @(negedge clk_sys);
    btn_stop = 1'b0;
    btn_go = 1'b0;
  endtask : press

  // Held across power-up for update entry
  task automatic hold(input logic s, input logic g);
    btn_stop = s;
    btn_go = g;
  endtask : hold

  task automatic short_rep(input logic e, input logic i);
    short_ext = e;
    short_int = i;
  endtask : short_rep
endmodule : olied_oper

// *** sim/tb_operating_state_led_indicator.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %0h expected %0h", $time, a, b); end end

module tb_operating_state_led_indicator;
  localparam int unsigned MSC = 2;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ext_upd_req = 1'b0;
  logic trk_sig_ok = 1'b1;
  logic brake_cfg = 1'b0;
  logic [7:0] sc_delay_code = 8'h01;
  logic cmd_on = 1'b0;
  olied_pkg::olied_cmd_s cmd_in = olied_pkg::CMD_RST;
  olied_pkg::olied_cmd_s cmd_out;
  olied_pkg::olied_cmd_s exp_c;
  olied_pkg::olied_led_s led;
  logic trk_pwr;
  logic btn_stop;
  logic btn_go;
  logic short_ext;
  logic short_int;
  olied_pkg::olied_cmd_s exp_q[$];
  int miscompares = 0;
  int n_compared = 0;
  int n;

  always #25 clk_sys = ~clk_sys;

  olied_oper oper (.clk_sys(clk_sys), .btn_stop(btn_stop), .btn_go(btn_go),
    .short_ext(short_ext), .short_int(short_int));

  olied_top #(.MS_CYCLES(MSC)) dut (.clk_sys(clk_sys), .nrst(nrst), .btn_stop(btn_stop),
    .btn_go(btn_go), .short_ext(short_ext), .short_int(short_int),
    .ext_upd_req(ext_upd_req), .trk_sig_ok(trk_sig_ok), .brake_cfg(brake_cfg),
    .sc_delay_code(sc_delay_code), .cmd_in(cmd_in), .cmd_out(cmd_out), .led(led),
    .trk_pwr(trk_pwr));

  // ----------------------------------------------------------------
  // Command stream model, checked every cycle while cmd_on is set
  // ----------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (!cmd_on) begin
      exp_q.delete();
    end else begin
      if (exp_q.size() > 0) begin
        exp_c = exp_q.pop_front();
        `CHK(cmd_out, exp_c)
      end
      cmd_in = {1'b1, 1'($urandom), 14'($urandom), 8'($urandom)};
      brake_cfg = 1'($urandom);
      exp_c = cmd_in;
      if (brake_cfg && exp_c.is_speed) begin
        exp_c.data = 8'h00;
      end
      exp_q.push_back(exp_c);
    end
  end

  task automatic reset_dut;
    @(negedge clk_sys);
    nrst = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK(led, 3'h0)
    `CHK(trk_pwr, 1'b0)
    nrst = 1'b1;
    repeat (10) @(negedge clk_sys);
  endtask : reset_dut

  // Cycles between two changes of one LED
  task automatic meas(input int b, output int n);
    logic v;
    int k;
    k = 0;
    @(negedge clk_sys);
    // Two changes first: the first may be the switch into the pattern
    repeat (2) begin
      v = led[b];
      while (led[b] === v && k < 5000) begin
        @(negedge clk_sys);
        k++;
      end
    end
    v = led[b];
    n = 0;
    while (led[b] === v && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : meas

  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  initial begin
    #(60000 * 50);
    miscompares++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(9));
    reset_dut();
    cmd_on = 1'b1;
    `CHK(trk_pwr, 1'b0)
    `CHK(led[2:1], 2'h2)
    meas(0, n);
    `CHK(n, 500 * MSC)
    oper.press(1'b0, 1'b1);
    `CHK(trk_pwr, 1'b1)
    @(negedge clk_sys);
    `CHK(led, 3'h3)
    oper.press(1'b1, 1'b1);
    `CHK(trk_pwr, 1'b0)
    @(negedge clk_sys);
    `CHK(led[2:1], 2'h2)
    oper.press(1'b0, 1'b1);
    trk_sig_ok = 1'b0;
    meas(0, n);
    `CHK(n, 500 * MSC)
    trk_sig_ok = 1'b1;
    for (int c = 1; c <= 2; c++) begin
      sc_delay_code = 8'(c);
      oper.short_rep(c == 2, c == 1);
      n = 0;
      while (trk_pwr === 1'b1 && n < 5000) begin
        @(negedge clk_sys);
        n++;
      end
      `CHK(n >= c * 5 * MSC && n <= (c * 5 + 1) * MSC + 2, 1'b1)
      meas(2, n);
      `CHK(n, 125 * MSC)
      `CHK(led.grn, 1'b0)
      if (c == 1) begin
        meas(0, n);
        `CHK(n, 125 * MSC)
      end
      oper.short_rep(1'b0, 1'b0);
      oper.press(1'b0, 1'b1);
      `CHK(trk_pwr, 1'b1)
    end
    sc_delay_code = 8'h00;
    oper.short_rep(1'b1, 1'b1);
    repeat (20 * MSC) @(negedge clk_sys);
    `CHK(trk_pwr, 1'b1)
    oper.short_rep(1'b0, 1'b0);
    ext_upd_req = 1'b1;
    @(negedge clk_sys);
    ext_upd_req = 1'b0;
    `CHK(trk_pwr, 1'b0)
    meas(2, n);
    `CHK(n, 500 * MSC)
    `CHK(led.grn, ~led.red)
    oper.press(1'b0, 1'b1);
    `CHK(trk_pwr, 1'b0)
    cmd_on = 1'b0;
    oper.hold(1'b1, 1'b1);
    reset_dut();
    oper.hold(1'b0, 1'b0);
    cmd_on = 1'b1;
    `CHK(led.grn, 1'b0)
    meas(2, n);
    `CHK(n, 500 * MSC)
    oper.press(1'b0, 1'b1);
    `CHK(trk_pwr, 1'b0)
    `CHK(led.grn, 1'b0)
    complete_run();
  end
endmodule : tb_operating_state_led_indicator
